// file: clk_postscaler.sv
/*
 * postscaler: makes a system tick enable dividing ref_clk by 1/4/16/64.
 * assumes the select comes from a register on the same clock.
 */
`timescale 1ns/1ps
module clk_postscaler (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   // control
   input  wire logic [1:0] post_sel,
   output logic            sys_tick
);
   logic [5:0] div_reg;

   // terminal count of the divider for a setting
   function automatic logic [5:0] div_last(input logic [1:0] s);
      case (s)
         nvm_seq_pkg::POST_DIV4:  div_last = 6'h03;
         nvm_seq_pkg::POST_DIV16: div_last = 6'h0f;
         nvm_seq_pkg::POST_DIV64: div_last = 6'h3f;
         default:                 div_last = 6'h00;
      endcase
   endfunction

   // counter compares with >=, so a change at any time never strands it
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         div_reg  <= 6'h00;
         sys_tick <= 1'b0;
      end else if (clk_en) begin
         if (div_reg >= div_last(post_sel)) begin
            div_reg  <= 6'h00;
            sys_tick <= 1'b1;
         end else begin
            div_reg  <= div_reg + 6'h01;
            sys_tick <= 1'b0;
         end
      end
   end

   // a tick restarts the divider, so except under divide by 1 no tick may follow at once
   property p_div64;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && sys_tick && post_sel == nvm_seq_pkg::POST_DIV64)
      |=> !sys_tick;
   endproperty
   a_div64: assert property (p_div64)
      else $error("tick repeated under divide by 64");

   property p_div4;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && sys_tick && post_sel == nvm_seq_pkg::POST_DIV4)
      ##1 (clk_en && post_sel == nvm_seq_pkg::POST_DIV4) [*3]
      |-> ##1 sys_tick;
   endproperty
   a_div4: assert property (p_div4)
      else $error("divide by 4 tick missing");

   property p_div1;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && post_sel == nvm_seq_pkg::POST_DIV1) |=> sys_tick;
   endproperty
   a_div1: assert property (p_div1)
      else $error("undivided tick missing");

   property p_div16;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && sys_tick && post_sel == nvm_seq_pkg::POST_DIV16)
      ##1 (clk_en && post_sel == nvm_seq_pkg::POST_DIV16) [*8]
      |-> !sys_tick;
   endproperty
   a_div16: assert property (p_div16)
      else $error("early tick under divide by 16");
endmodule

// file: eeprom_write_timing_sequencer.sv
/*
 * eeprom write/erase cycle sequencer with unlock, interrupt-terminated
 * cycles, read throttling postscaler and reset-during-programming trap.
 * assumes a cpu-side register port and an acknowledge pulse from the
 * interrupt controller on the same clock.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - self timing unreliable; self-timed end only when termination bit clear
// - termination bit set: cycle ends on next acknowledged interrupt
// - start accepted only after keys 0x55 then 0xaa
// - postscaler divides system clock by 4, 16 or 64, changeable anytime
// - reset during self-programming raises an address error trap
module eeprom_write_timing_sequencer #(
   parameter int SELF_TIME_CYC = nvm_seq_pkg::SELF_TIME_CYC
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // interrupt acknowledge from the cpu, and device reset cause
   input  wire logic        irq_ack,
   input  wire logic        dev_reset_req,
   // outputs
   output logic             cycle_busy,
   output logic             sys_tick,
   output logic             irq
);
   // the self timer is 31 bits wide and must count at least once
   if (SELF_TIME_CYC < 1 || SELF_TIME_CYC > 2**30) begin : g_bad_time
      $error("SELF_TIME_CYC out of range");
   end

   nvm_seq_pkg::reg_req_t req;
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   logic [15:0] ctrl_reg;
   logic [1:0]  post_reg;
   logic [2:0]  ev_status_reg;
   logic [2:0]  ev_enable_reg;
   logic [1:0]  trap_reg;
   logic [15:0] ee_data_reg;
   logic [30:0] timer_reg;
   logic        prog_mark_reg;
   nvm_seq_pkg::unlock_state_t key_reg;

   logic start_ok;
   logic cycle_end;
   logic wr_ctrl;
   logic wr_key;
   logic sys_tick_int;

   function automatic logic hit(input nvm_seq_pkg::reg_req_t r,
                                input logic [3:0] a);
      hit = r.wr && (r.addr == a);
   endfunction

   assign wr_ctrl = hit(req, nvm_seq_pkg::ADDR_NVM_CONTROL);
   assign wr_key  = hit(req, nvm_seq_pkg::ADDR_NVM_KEY);
   assign start_ok = wr_ctrl && reg_wdata[nvm_seq_pkg::CTRL_START_BIT]
                     && key_reg == nvm_seq_pkg::ST_ARMED
                     && !ctrl_reg[nvm_seq_pkg::CTRL_START_BIT];

   // cycle end: interrupt ack when termination bit set, else own timer
   assign cycle_end = ctrl_reg[nvm_seq_pkg::CTRL_START_BIT] &&
      (ctrl_reg[nvm_seq_pkg::CTRL_ITW_BIT] ? irq_ack
       : (timer_reg >= 31'(SELF_TIME_CYC - 1)));

   // unlock sequencer: any other write to the key disarms it
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         key_reg <= nvm_seq_pkg::ST_IDLE;
      end else if (clk_en) begin
         if (wr_key) begin
            case (key_reg)
               nvm_seq_pkg::ST_IDLE:
                  key_reg <= (reg_wdata == nvm_seq_pkg::KEY_FIRST) ?
                     nvm_seq_pkg::ST_KEY1 : nvm_seq_pkg::ST_IDLE;
               nvm_seq_pkg::ST_KEY1:
                  key_reg <= (reg_wdata == nvm_seq_pkg::KEY_SECOND) ?
                     nvm_seq_pkg::ST_ARMED : nvm_seq_pkg::ST_IDLE;
               default:
                  key_reg <= nvm_seq_pkg::ST_IDLE;
            endcase
         end else if (wr_ctrl) begin
            key_reg <= nvm_seq_pkg::ST_IDLE; // keys are single use
         end
      end
   end

   // control register and start bit
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ctrl_reg <= 16'h0000;
      end else if (clk_en) begin
         if (cycle_end) begin
            ctrl_reg[nvm_seq_pkg::CTRL_START_BIT] <= 1'b0;
         end else if (wr_ctrl && !ctrl_reg[nvm_seq_pkg::CTRL_START_BIT]) begin
            // fields are frozen while a cycle runs
            ctrl_reg <= (reg_wdata & nvm_seq_pkg::CTRL_WMASK)
                        | {start_ok, 15'h0000};
         end
      end
   end

   // self-timing counter, counts only while a cycle runs
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         timer_reg <= 31'h00000000;
      end else if (clk_en) begin
         // held at zero under interrupt termination, so it cannot overrun
         if (ctrl_reg[nvm_seq_pkg::CTRL_START_BIT]
             && !ctrl_reg[nvm_seq_pkg::CTRL_ITW_BIT] && !cycle_end)
            timer_reg <= timer_reg + 31'h00000001;
         else
            timer_reg <= 31'h00000000;
      end
   end

   // model of the stored word, written from the register port while no cycle runs
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ee_data_reg <= 16'h0000;
      end else if (clk_en) begin
         if (hit(req, nvm_seq_pkg::ADDR_EE_DATA)
             && !ctrl_reg[nvm_seq_pkg::CTRL_START_BIT])
            ee_data_reg <= reg_wdata;
      end
   end

   // programming mark follows the start bit, cleared by the device reset request and by reset_n
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         prog_mark_reg <= 1'b0;
      end else if (clk_en) begin
         if (dev_reset_req)
            prog_mark_reg <= 1'b0;
         else
            prog_mark_reg <= ctrl_reg[nvm_seq_pkg::CTRL_START_BIT];
      end
   end

   // trap flags: set by reset during a running cycle, set beats clear
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         trap_reg <= 2'h0;
      end else if (clk_en) begin
         if (dev_reset_req && prog_mark_reg)
            trap_reg <= 2'h3;
         else if (hit(req, nvm_seq_pkg::ADDR_TRAP_FLAGS))
            trap_reg <= trap_reg & ~reg_wdata[1:0];
      end
   end

   // oscillator control postscaler field, writable at any time
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         post_reg <= nvm_seq_pkg::POST_DIV1;
      end else if (clk_en) begin
         if (hit(req, nvm_seq_pkg::ADDR_OSC_CONTROL))
            post_reg <= reg_wdata[nvm_seq_pkg::OSC_POST_LSB +: 2];
      end
   end

   clk_postscaler u_post (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .post_sel (post_reg),
      .sys_tick (sys_tick_int)
   );

   // interrupt status and enable; set wins over a same-cycle clear
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ev_status_reg <= 3'h0;
         ev_enable_reg <= 3'h0;
      end else if (clk_en) begin
         logic [2:0] set_v;
         logic [2:0] clr_v;
         set_v = {dev_reset_req && prog_mark_reg,
                  wr_ctrl && reg_wdata[nvm_seq_pkg::CTRL_START_BIT]
                     && !start_ok,
                  cycle_end};
         clr_v = hit(req, nvm_seq_pkg::ADDR_IRQ_CLEAR) ? reg_wdata[2:0]
                                                       : 3'h0;
         ev_status_reg <= (ev_status_reg & ~clr_v) | set_v;
         if (hit(req, nvm_seq_pkg::ADDR_IRQ_ENABLE))
            ev_enable_reg <= reg_wdata[2:0];
      end
   end

   // registered outputs and read data
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reg_rdata  <= 16'h0000;
         cycle_busy <= 1'b0;
         sys_tick   <= 1'b0;
         irq        <= 1'b0;
      end else if (clk_en) begin
         cycle_busy <= ctrl_reg[nvm_seq_pkg::CTRL_START_BIT] && !cycle_end;
         sys_tick   <= sys_tick_int;
         irq        <= |(ev_status_reg & ev_enable_reg);
         if (!reg_rd)
            reg_rdata <= 16'h0000;
         else if (reg_addr == nvm_seq_pkg::ADDR_NVM_CONTROL)
            reg_rdata <= ctrl_reg;
         else if (reg_addr == nvm_seq_pkg::ADDR_OSC_CONTROL)
            reg_rdata <= {8'h00, post_reg, 6'h00};
         else if (reg_addr == nvm_seq_pkg::ADDR_IRQ_STATUS)
            reg_rdata <= {13'h0000, ev_status_reg};
         else if (reg_addr == nvm_seq_pkg::ADDR_IRQ_ENABLE)
            reg_rdata <= {13'h0000, ev_enable_reg};
         else if (reg_addr == nvm_seq_pkg::ADDR_TRAP_FLAGS)
            reg_rdata <= {14'h0000, trap_reg};
         else if (reg_addr == nvm_seq_pkg::ADDR_EE_DATA)
            reg_rdata <= ee_data_reg;
         else
            reg_rdata <= 16'h0000;
      end
   end

   property p_no_start_unarmed;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && wr_ctrl && key_reg != nvm_seq_pkg::ST_ARMED
       && !ctrl_reg[nvm_seq_pkg::CTRL_START_BIT])
      |=> !ctrl_reg[nvm_seq_pkg::CTRL_START_BIT];
   endproperty
   a_no_start_unarmed: assert property (p_no_start_unarmed)
      else $error("start accepted without unlock");

   property p_start_taken;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && start_ok) |=> ctrl_reg[nvm_seq_pkg::CTRL_START_BIT];
   endproperty
   a_start_taken: assert property (p_start_taken)
      else $error("unlocked start not taken");

   property p_ack_ends;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && ctrl_reg[nvm_seq_pkg::CTRL_START_BIT]
       && ctrl_reg[nvm_seq_pkg::CTRL_ITW_BIT] && irq_ack)
      |=> !ctrl_reg[nvm_seq_pkg::CTRL_START_BIT] && !cycle_busy;
   endproperty
   a_ack_ends: assert property (p_ack_ends)
      else $error("acknowledge did not end cycle");

   property p_self_time;
      @(posedge ref_clk) disable iff (!reset_n)
      timer_reg < 31'(SELF_TIME_CYC);
   endproperty
   a_self_time: assert property (p_self_time)
      else $error("self timer overran");

   property p_trap;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && dev_reset_req && prog_mark_reg) |=> trap_reg == 2'h3;
   endproperty
   a_trap: assert property (p_trap)
      else $error("trap not raised");

   property p_trap_status;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && dev_reset_req && prog_mark_reg)
      |=> ev_status_reg[nvm_seq_pkg::EV_TRAP];
   endproperty
   a_trap_status: assert property (p_trap_status)
      else $error("trap event not latched");

   property p_busy_clear;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && cycle_end) |=> !cycle_busy;
   endproperty
   a_busy_clear: assert property (p_busy_clear)
      else $error("busy stuck after end");

   property p_irq_level;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_en && |(ev_status_reg & ev_enable_reg)) |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("enabled event without interrupt");
endmodule

// file: eeprom_write_timing_sequencer_bench.sv
/*
 * self-checking bench for the eeprom write timing sequencer.
 * assumes the design package is compiled first; the bench drives the
 * register port, interrupt acknowledge and device reset itself.
 */
`timescale 1ns/1ps
module eeprom_write_timing_sequencer_bench;
   localparam int SELF_CYC = 20;
   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        clk_en = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic        irq_ack = 1'b0;
   logic        dev_reset_req = 1'b0;
   logic        cycle_busy;
   logic        sys_tick;
   logic        irq;
   int          n_fail = 0;
   int          n_compared = 0;
   int          n;
   logic [15:0] d;
   // ordinary register rows: address, write data, read mask, readback
   typedef struct {
      logic [3:0] a; logic [15:0] w; logic [15:0] m; logic [15:0] e;
   } row_t;
   row_t rows [3] = '{
      '{nvm_seq_pkg::ADDR_NVM_CONTROL, 16'h4105, 16'hffff, 16'h4105},
      '{nvm_seq_pkg::ADDR_IRQ_ENABLE,  16'h0007, 16'h0007, 16'h0007},
      '{nvm_seq_pkg::ADDR_OSC_CONTROL, 16'h00c0, 16'h00c0, 16'h00c0}};
   logic [15:0] tick_exp [4] = '{16'h0100, 16'h0040, 16'h0010, 16'h0004};

   eeprom_write_timing_sequencer #(.SELF_TIME_CYC(SELF_CYC)) u_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
      .dev_reset_req(dev_reset_req), .cycle_busy(cycle_busy),
      .sys_tick(sys_tick), .irq(irq));

   // 200 MHz clock
   always #2.5 ref_clk = ~ref_clk;

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one-cycle write, strobe dropped at the taking edge
   task automatic wr(input logic [3:0] a, input logic [15:0] w);
      @(posedge ref_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= w;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge ref_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      v = reg_rdata;
   endtask

   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic unlock();
      wr(nvm_seq_pkg::ADDR_NVM_KEY, nvm_seq_pkg::KEY_FIRST);
      wr(nvm_seq_pkg::ADDR_NVM_KEY, nvm_seq_pkg::KEY_SECOND);
   endtask

   // acknowledge of the single terminating timer interrupt
   task automatic pulse_ack();
      @(posedge ref_clk);
      irq_ack <= 1'b1;
      @(posedge ref_clk);
      irq_ack <= 1'b0;
   endtask

   // watchdog, far beyond the expected run of under two thousand cycles
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      #1;
      check("busy_after_reset", {15'h0, cycle_busy}, 16'h0000);
      check("irq_after_reset", {15'h0, irq}, 16'h0000);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, d);
         check("row_readback", d & rows[i].m, rows[i].e);
      end
      // each postscaler setting: ticks in a 256-cycle window
      for (int s = 0; s < 4; s++) begin
         wr(nvm_seq_pkg::ADDR_OSC_CONTROL, 16'(s) << 6);
         repeat (80) @(posedge ref_clk);
         n = 0;
         repeat (256) begin
            @(posedge ref_clk);
            #1;
            if (sys_tick === 1'b1) n++;
         end
         check("tick_count", 16'(n), tick_exp[s]);
      end
      wr(nvm_seq_pkg::ADDR_OSC_CONTROL, 16'h0000);
      wr(nvm_seq_pkg::ADDR_IRQ_ENABLE, 16'h0001);
      // start with keys missing, then keys in the wrong order
      wr(nvm_seq_pkg::ADDR_NVM_CONTROL, 16'hc105);
      wr(nvm_seq_pkg::ADDR_NVM_KEY, nvm_seq_pkg::KEY_SECOND);
      wr(nvm_seq_pkg::ADDR_NVM_KEY, nvm_seq_pkg::KEY_FIRST);
      wr(nvm_seq_pkg::ADDR_NVM_CONTROL, 16'hc105);
      settle();
      check("busy_refused", {15'h0, cycle_busy}, 16'h0000);
      rd(nvm_seq_pkg::ADDR_NVM_CONTROL, d);
      check("start_refused", d & 16'h8000, 16'h0000);
      rd(nvm_seq_pkg::ADDR_IRQ_STATUS, d);
      check("abort_status", d & 16'h0002, 16'h0002);
      check("irq_masked", {15'h0, irq}, 16'h0000);
      wr(nvm_seq_pkg::ADDR_IRQ_CLEAR, 16'h0007);
      // eeprom read only after the clock is slowed by four
      wr(nvm_seq_pkg::ADDR_OSC_CONTROL, 16'h0040);
      wr(nvm_seq_pkg::ADDR_EE_DATA, 16'h5a3c);
      rd(nvm_seq_pkg::ADDR_EE_DATA, d);
      check("ee_readback", d, 16'h5a3c);
      // interrupt-terminated cycle outlives its self timing
      unlock();
      wr(nvm_seq_pkg::ADDR_NVM_CONTROL, 16'hc105);
      // timer period twice the scaled 2 ms self time, inside the window
      repeat (2 * SELF_CYC) @(posedge ref_clk);
      #1;
      check("busy_held", {15'h0, cycle_busy}, 16'h0001);
      rd(nvm_seq_pkg::ADDR_NVM_CONTROL, d);
      check("start_held", d & 16'h8000, 16'h8000);
      // data word is frozen while the cycle runs
      wr(nvm_seq_pkg::ADDR_EE_DATA, 16'hffff);
      pulse_ack();
      settle();
      check("busy_ended", {15'h0, cycle_busy}, 16'h0000);
      check("irq_done", {15'h0, irq}, 16'h0001);
      rd(nvm_seq_pkg::ADDR_NVM_CONTROL, d);
      check("start_cleared", d & 16'h8000, 16'h0000);
      rd(nvm_seq_pkg::ADDR_EE_DATA, d);
      check("ee_held", d, 16'h5a3c);
      wr(nvm_seq_pkg::ADDR_IRQ_CLEAR, 16'h0001);
      settle();
      check("irq_cleared", {15'h0, irq}, 16'h0000);
      // self-timed cycle with the termination bit clear
      unlock();
      wr(nvm_seq_pkg::ADDR_NVM_CONTROL, 16'h8005);
      n = 0;
      while ((cycle_busy !== 1'b0 || n < 2) && n <= 100) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      // busy rises one edge after start and falls at the ending edge
      check("self_end", 16'(n), 16'(SELF_CYC));
      rd(nvm_seq_pkg::ADDR_NVM_CONTROL, d);
      check("self_start", d & 16'h8000, 16'h0000);
      // device reset while a cycle runs, then the handler clears flags
      wr(nvm_seq_pkg::ADDR_IRQ_CLEAR, 16'h0007);
      unlock();
      wr(nvm_seq_pkg::ADDR_NVM_CONTROL, 16'hc105);
      settle();
      @(posedge ref_clk);
      dev_reset_req <= 1'b1;
      @(posedge ref_clk);
      dev_reset_req <= 1'b0;
      settle();
      rd(nvm_seq_pkg::ADDR_TRAP_FLAGS, d);
      check("trap_flags", d & 16'h0003, 16'h0003);
      rd(nvm_seq_pkg::ADDR_IRQ_STATUS, d);
      check("trap_status", d & 16'h0004, 16'h0004);
      wr(nvm_seq_pkg::ADDR_TRAP_FLAGS, 16'h0003);
      rd(nvm_seq_pkg::ADDR_TRAP_FLAGS, d);
      check("trap_cleared", d & 16'h0003, 16'h0000);
      pulse_ack();
      // a write while the clock enable is low must be ignored
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(nvm_seq_pkg::ADDR_EE_DATA, 16'h0f0f);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      rd(nvm_seq_pkg::ADDR_EE_DATA, d);
      check("ee_frozen", d, 16'h5a3c);
      // second reset with no cycle running clears the control register
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(nvm_seq_pkg::ADDR_NVM_CONTROL, d);
      check("ctrl_after_reset", d, 16'h0000);
      check("busy_after_reset2", {15'h0, cycle_busy}, 16'h0000);
      report_and_stop();
   end
endmodule

// file: nvm_seq_pkg.sv
/*
 * constants and carriers for the eeprom write timing sequencer.
 * assumes a 200 MHz ref_clk and a word-wide register port.
 */
package nvm_seq_pkg;
   // register indices on the plain register port
   localparam logic [3:0] ADDR_NVM_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_NVM_KEY     = 4'h1;
   localparam logic [3:0] ADDR_OSC_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h3;
   localparam logic [3:0] ADDR_IRQ_CLEAR   = 4'h4;
   localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'h5;
   localparam logic [3:0] ADDR_TRAP_FLAGS  = 4'h6;
   localparam logic [3:0] ADDR_EE_DATA     = 4'h7;

   // control register fields
   localparam int CTRL_START_BIT = 15;
   localparam int CTRL_ERR_BIT   = 13;
   localparam int CTRL_ITW_BIT   = 8;
   localparam int CTRL_OP_LSB    = 0;
   localparam int CTRL_OP_W      = 7;
   localparam logic [15:0] CTRL_WMASK = 16'h417f;

   // unlock keys
   localparam logic [15:0] KEY_FIRST  = 16'h0055;
   localparam logic [15:0] KEY_SECOND = 16'h00aa;

   // oscillator postscaler field
   localparam int OSC_POST_LSB = 6;
   localparam logic [1:0] POST_DIV1  = 2'h0;
   localparam logic [1:0] POST_DIV4  = 2'h1;
   localparam logic [1:0] POST_DIV16 = 2'h2;
   localparam logic [1:0] POST_DIV64 = 2'h3;

   // trap flag bits
   localparam int TRAP_RESET_BIT = 0;
   localparam int ADDR_ERR_BIT   = 1;

   // interrupt status bits
   localparam int EV_DONE  = 0;
   localparam int EV_ABORT = 1;
   localparam int EV_TRAP  = 2;

   // self timing of the cycle (unreliable on this silicon)
   localparam int CLK_MHZ        = 200;
   localparam int SELF_TIME_US   = 2000;
   localparam int SELF_TIME_CYC  = SELF_TIME_US * CLK_MHZ;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_KEY1  = 3'b010,
      ST_ARMED = 3'b100
   } unlock_state_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;
endpackage
